// File: common/link_flags_pkg.sv
// Package: offsets, reset values and field positions of the link flag bank
package link_flags_pkg;

  // Sizes
  localparam int unsigned NUM_STATIONS = 16;
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned IRQ_W        = 3;
  localparam int unsigned STN_IDX_W    = 5;

  // Register byte offsets
  localparam logic [7:0] ERR_WORD_OFFSET    = 8'h00;
  localparam logic [7:0] ASSURE_WORD_OFFSET = 8'h04;
  localparam logic [7:0] RUN_WORD_OFFSET    = 8'h08;
  localparam logic [7:0] INT_STATUS_OFFSET  = 8'h0c;
  localparam logic [7:0] INT_MASK_OFFSET    = 8'h10;
  localparam logic [7:0] CTRL_OFFSET        = 8'h14;
  localparam logic [7:0] LOST_WORD_OFFSET   = 8'h18;
  localparam logic [7:0] ERR_COUNT_OFFSET   = 8'h1c;

  // Field positions
  localparam int unsigned ERR_FLAG_BIT     = 0;
  localparam int unsigned IRQ_ERR_BIT      = 0;
  localparam int unsigned IRQ_LOST_BIT     = 1;
  localparam int unsigned IRQ_MODE_BIT     = 2;
  localparam int unsigned CTRL_LINK_EN_BIT = 0;
  localparam int unsigned CTRL_COUNT_LSB   = 8;

  // Values after reset
  localparam logic [15:0]   ERR_WORD_RESET   = 16'h0000;
  localparam logic [15:0]   ASSURE_RESET     = 16'h0000;
  localparam logic [15:0]   RUN_RESET        = 16'h0000;
  localparam logic [15:0]   LOST_RESET       = 16'h0000;
  localparam logic [15:0]   ERR_COUNT_RESET  = 16'h0000;
  localparam logic [2:0]    INT_STATUS_RESET = 3'h0;
  localparam logic [2:0]    INT_MASK_RESET   = 3'h0;
  localparam logic          LINK_EN_RESET    = 1'b1;
  localparam logic [4:0]    STN_COUNT_RESET  = 5'h10;

endpackage

// File: hdl/link_status_flags.sv
// Link status flag bank: error flag, station assurance and run-mode words
module link_status_flags #(
  parameter int unsigned NUM_STATIONS = link_flags_pkg::NUM_STATIONS
) (
  input  wire logic        clock,
  input  wire logic        arst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  // Protocol engine side
  input  wire logic        scan_update,
  input  wire logic        link_in_use,
  input  wire logic        link_tx_error,
  input  wire logic        link_area_invalid,
  input  wire logic [15:0] station_ok,
  input  wire logic [15:0] station_stopped,
  input  wire logic [15:0] station_error,
  input  wire logic [15:0] station_run
);

  typedef struct packed {
    logic [31:0] prdata;
    logic        pslverr;
    logic        irq;
    logic        err_pend;
    logic        err_flag;
    logic [2:0]  int_status;
    logic [2:0]  int_mask;
    logic        link_en;
    logic [4:0]  stn_count;
    logic [15:0] lost_word;
    logic [15:0] err_count;
  } bank_state_t;

  bank_state_t st_q;
  bank_state_t st_d;

  logic [15:0] assure_word;
  logic [15:0] run_word;
  logic [15:0] lost_ev;
  logic [15:0] mode_ev;
  logic [15:0] configured;
  logic        link_active;
  logic        setup_phase;
  logic        wr_access;
  logic        tx_err_seen;
  logic [15:0] err_word;

  // Link mode counts as active only when software has not switched it off
  assign link_active = link_in_use & st_q.link_en;

  // Stations above the configured count never report assurance
  always_comb begin
    configured = '0;
    for (int i = 0; i < 16; i++) begin
      configured[i] = (i < int'(st_q.stn_count));
    end
  end

  // Per-station flag cells; unused positions read zero
  for (genvar g = 0; g < 16; g++) begin : g_station
    if (g < NUM_STATIONS) begin : g_used
      station_flag u_station (
        .clock       (clock),
        .arst_n      (arst_n),
        .scan_update (scan_update),
        .link_active (link_active),
        .configured  (configured[g]),
        .ok          (station_ok[g]),
        .stopped     (station_stopped[g]),
        .error       (station_error[g]),
        .run         (station_run[g]),
        .assured     (assure_word[g]),
        .run_mode    (run_word[g]),
        .lost        (lost_ev[g]),
        .mode_change (mode_ev[g])
      );
    end else begin : g_unused
      assign assure_word[g] = 1'b0;
      assign run_word[g]    = 1'b0;
      assign lost_ev[g]     = 1'b0;
      assign mode_ev[g]     = 1'b0;
    end
  end

  // Only bit 0 of the error word carries state
  assign err_word = {15'h0000, st_q.err_flag};

  // APB phase decode
  assign setup_phase = psel & ~penable;
  assign wr_access   = psel & penable & pwrite;

  // Error seen during the link's active period
  assign tx_err_seen = link_active & link_tx_error;

  // Next state of the whole bank
  always_comb begin
    st_d = st_q;

    // Errors between scans are held until the next scan boundary
    if (scan_update) begin
      st_d.err_pend = 1'b0;
    end
    if (tx_err_seen) begin
      st_d.err_pend = 1'b1;
    end

    // Flag is recomputed per scan from pending errors and area check
    if (scan_update) begin
      st_d.err_flag = link_in_use
                      & (st_q.err_pend | tx_err_seen
                         | link_area_invalid);
    end

    // Saturating count of transmission errors
    if (tx_err_seen && st_q.err_count != 16'hffff) begin
      st_d.err_count = st_q.err_count + 16'h0001;
    end

    // Read data and error are captured in the setup cycle
    if (setup_phase) begin
      st_d.prdata  = 32'h0000_0000;
      st_d.pslverr = 1'b0;
      if (paddr == link_flags_pkg::ERR_WORD_OFFSET) begin
        st_d.prdata = {16'h0000, err_word};
      end else if (paddr == link_flags_pkg::ASSURE_WORD_OFFSET) begin
        st_d.prdata = {16'h0000, assure_word};
      end else if (paddr == link_flags_pkg::RUN_WORD_OFFSET) begin
        st_d.prdata = {16'h0000, run_word};
      end else if (paddr == link_flags_pkg::INT_STATUS_OFFSET) begin
        st_d.prdata = {29'h0000_0000, st_q.int_status};
      end else if (paddr == link_flags_pkg::INT_MASK_OFFSET) begin
        st_d.prdata = {29'h0000_0000, st_q.int_mask};
      end else if (paddr == link_flags_pkg::CTRL_OFFSET) begin
        st_d.prdata = {19'h0_0000, st_q.stn_count,
                       7'h00, st_q.link_en};
      end else if (paddr == link_flags_pkg::LOST_WORD_OFFSET) begin
        st_d.prdata = {16'h0000, st_q.lost_word};
      end else if (paddr == link_flags_pkg::ERR_COUNT_OFFSET) begin
        st_d.prdata = {16'h0000, st_q.err_count};
      end else begin
        // Unmapped or misaligned address
        st_d.pslverr = 1'b1;
      end
    end

    // Writes: status flag words are read-only and drop writes silently
    if (wr_access && !st_q.pslverr) begin
      if (paddr == link_flags_pkg::INT_STATUS_OFFSET) begin
        if (pstrb[0]) begin
          st_d.int_status = st_q.int_status & ~pwdata[2:0];
        end
      end else if (paddr == link_flags_pkg::INT_MASK_OFFSET) begin
        if (pstrb[0]) begin
          st_d.int_mask = pwdata[2:0];
        end
      end else if (paddr == link_flags_pkg::CTRL_OFFSET) begin
        if (pstrb[0]) begin
          st_d.link_en = pwdata[link_flags_pkg::CTRL_LINK_EN_BIT];
        end
        if (pstrb[1]) begin
          st_d.stn_count = pwdata[12:8];
        end
      end else if (paddr == link_flags_pkg::LOST_WORD_OFFSET) begin
        if (pstrb[0]) begin
          st_d.lost_word[7:0] = st_q.lost_word[7:0] & ~pwdata[7:0];
        end
        if (pstrb[1]) begin
          st_d.lost_word[15:8] = st_q.lost_word[15:8] & ~pwdata[15:8];
        end
      end else if (paddr == link_flags_pkg::ERR_COUNT_OFFSET) begin
        if (pstrb[0] || pstrb[1]) begin
          st_d.err_count = link_flags_pkg::ERR_COUNT_RESET;
        end
      end
    end

    // Sticky events are set after any clear so a same-cycle event wins
    st_d.lost_word = st_d.lost_word | lost_ev;
    if (scan_update && !st_q.err_flag && st_d.err_flag) begin
      st_d.int_status[link_flags_pkg::IRQ_ERR_BIT] = 1'b1;
    end
    if (|lost_ev) begin
      st_d.int_status[link_flags_pkg::IRQ_LOST_BIT] = 1'b1;
    end
    if (|mode_ev) begin
      st_d.int_status[link_flags_pkg::IRQ_MODE_BIT] = 1'b1;
    end

    // Level interrupt is registered in the same cycle as the gated status
    st_d.irq = |(st_d.int_status & st_d.int_mask);
  end

  // Single register stage for the bank
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_q.prdata     <= 32'h0000_0000;
      st_q.pslverr    <= 1'b0;
      st_q.irq        <= 1'b0;
      st_q.err_pend   <= 1'b0;
      st_q.err_flag   <= link_flags_pkg::ERR_WORD_RESET[0];
      st_q.int_status <= link_flags_pkg::INT_STATUS_RESET;
      st_q.int_mask   <= link_flags_pkg::INT_MASK_RESET;
      st_q.link_en    <= link_flags_pkg::LINK_EN_RESET;
      st_q.stn_count  <= link_flags_pkg::STN_COUNT_RESET;
      st_q.lost_word  <= link_flags_pkg::LOST_RESET;
      st_q.err_count  <= link_flags_pkg::ERR_COUNT_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Zero-wait slave: data were prepared during the setup cycle
  assign pready  = 1'b1;
  assign prdata  = st_q.prdata;
  assign pslverr = st_q.pslverr & psel & penable;
  assign irq     = st_q.irq;

endmodule

// File: hdl/station_flag.sv
// One station's assurance and run-mode flags, refreshed once per scan
module station_flag (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic scan_update,
  input  wire logic link_active,
  input  wire logic configured,
  input  wire logic ok,
  input  wire logic stopped,
  input  wire logic error,
  input  wire logic run,
  output logic      assured,
  output logic      run_mode,
  output logic      lost,
  output logic      mode_change
);

  typedef struct packed {
    logic assured;
    logic run_mode;
  } station_state_t;

  station_state_t st_q;
  station_state_t st_d;

  // Flags only move at a scan boundary so software sees a stable word
  always_comb begin
    st_d = st_q;
    if (scan_update) begin
      st_d.assured  = link_active & configured & ok
                      & ~stopped & ~error;
      st_d.run_mode = run;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Registered flags; edge events lost and mode_change are valid in the update cycle only
  assign assured     = st_q.assured;
  assign run_mode    = st_q.run_mode;
  assign lost        = st_q.assured & ~st_d.assured;
  assign mode_change = st_q.run_mode ^ st_d.run_mode;

endmodule

// File: sim/link_status_flags_props.sv
// Checker: flag words on APB reads against the last scan's inputs
module link_status_flags_props #(
  parameter int unsigned NUM_STATIONS = 16
) (
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        scan_update,
  input wire logic        link_in_use,
  input wire logic        link_tx_error,
  input wire logic        link_area_invalid,
  input wire logic [15:0] station_ok,
  input wire logic [15:0] station_stopped,
  input wire logic [15:0] station_error,
  input wire logic [15:0] station_run
);
  logic [15:0] run_s, as_s, good;
  logic        err_s, inv_s, pend, rd;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Read setup away from a scan edge, so the word is settled
  assign rd   = psel && !penable && !pwrite && !scan_update;
  assign good = station_ok & ~station_stopped & ~station_error;
  // Shadow of the last scan; assumes link enable and count stay at reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      {run_s, as_s, err_s, inv_s, pend} <= '0;
    end else if (scan_update) begin
      run_s <= station_run;
      as_s  <= link_in_use ? good : 16'h0000;
      err_s <= link_in_use & (pend | link_tx_error | link_area_invalid);
      inv_s <= link_in_use & link_area_invalid;
      // An error in the scan cycle also counts towards the next scan
      pend  <= link_tx_error & link_in_use;
    end else begin
      pend <= pend | (link_tx_error & link_in_use);
    end
  end
  property p_err; rd && paddr == 8'h00 |=> prdata[0] == err_s; endproperty
  a_err: assert property (p_err) else $error("error flag wrong");
  property p_inv; rd && paddr == 8'h00 && inv_s |=> prdata[0]; endproperty
  a_inv: assert property (p_inv) else $error("area error lost");
  property p_as; rd && paddr == 8'h04 |=> prdata[15:0] == as_s; endproperty
  a_as: assert property (p_as) else $error("assurance wrong");
  property p_off;
    scan_update && !link_in_use ##1 rd && paddr == 8'h04
      |=> prdata[15:0] == 16'h0000;
  endproperty
  a_off: assert property (p_off) else $error("assured, link off");
  property p_run; rd && paddr == 8'h08 |=> prdata[15:0] == run_s; endproperty
  a_run: assert property (p_run) else $error("run word wrong");
  property p_program_mode; rd && paddr == 8'h08 |=> (prdata[15:0] & ~run_s) == '0;
  endproperty
  a_program_mode: assert property (p_program_mode) else $error("program mode set");
  property p_zero; rd && paddr == 8'h00 |=> prdata[31:1] == '0; endproperty
  a_zero: assert property (p_zero) else $error("unused bits set");
  c_err: cover property (rd && paddr == 8'h00 ##1 prdata[0]);
  c_as: cover property (rd && paddr == 8'h04 ##1 prdata[15]);
  c_run: cover property (rd && paddr == 8'h08 ##1 prdata[0]);
endmodule

bind link_status_flags link_status_flags_props #(
  .NUM_STATIONS(NUM_STATIONS)
) u_props (
  .clock, .arst_n, .psel, .penable, .pwrite, .paddr, .prdata, .scan_update,
  .link_in_use, .link_tx_error, .link_area_invalid, .station_ok,
  .station_stopped, .station_error, .station_run
);

// File: sim/scan_model.sv
// Scan engine stand-in: one scan pulse every PERIOD cycles
module scan_model #(
  parameter int unsigned PERIOD = 16
) (
  input  wire logic clock,
  input  wire logic arst_n,
  output logic      scan_update
);
  logic [7:0] cnt_q;
  // One-cycle pulse; a long period leaves room for reads between scans
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q       <= 8'h00;
      scan_update <= 1'b0;
    end else begin
      cnt_q       <= (cnt_q == 8'(PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
      scan_update <= (cnt_q == 8'(PERIOD - 1));
    end
  end
endmodule

// File: sim/testbench.sv
// Testbench: flag bank through APB beside a scan engine model
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [2:0]  lk;
    logic [15:0] ok, stp, er, run;
  } row_t;
  // Link on, tx error, area invalid; stations 1 and 16 at the edges
  localparam row_t ROWS [5] = '{
    '{3'b100, 16'hffff, 16'h0000, 16'h0000, 16'hffff},
    '{3'b110, 16'hffff, 16'h0001, 16'h8000, 16'ha5a5},
    '{3'b101, 16'h0f0f, 16'h0000, 16'h0000, 16'h0000},
    '{3'b011, 16'hffff, 16'h0000, 16'h0000, 16'h5a5a},
    '{3'b100, 16'h0000, 16'h0000, 16'h0000, 16'h0001}};
  localparam logic [31:0] RST [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    {19'h0, link_flags_pkg::STN_COUNT_RESET, 7'h0,
     link_flags_pkg::LINK_EN_RESET}, 32'h0, 32'h0};
  logic        clock, arst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic        scan_update, link_in_use, link_tx_error, link_area_invalid;
  logic        rerr;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] station_ok, station_stopped, station_error, station_run;
  int          n_errors, total_checks, cycles;
  row_t        r;

  link_status_flags dut (
    .clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .irq, .scan_update, .link_in_use,
    .link_tx_error, .link_area_invalid, .station_ok, .station_stopped,
    .station_error, .station_run
  );
  scan_model #(.PERIOD(16)) engine (.clock, .arst_n, .scan_update);

  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles needed
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      tally_and_finish;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer; an idle edge after it keeps drives apart
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic scan_wait;
    do @(posedge clock); while (scan_update !== 1'b1);
  endtask

  initial begin
    {arst_n, psel, penable, pwrite, link_tx_error, paddr, pwdata} = '0;
    {link_in_use, link_area_invalid, station_ok, station_stopped,
     station_error, station_run} = '0;
    pstrb = 4'hf;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    foreach (ROWS[i]) begin
      r = ROWS[i];
      {link_in_use, link_area_invalid, station_ok, station_stopped,
       station_error, station_run} <= {r.lk[2], r.lk[0], r.ok, r.stp,
       r.er, r.run};
      scan_wait;
      link_tx_error <= r.lk[1];
      @(posedge clock);
      link_tx_error <= 1'b0;
      scan_wait;
      apb(1'b0, link_flags_pkg::ERR_WORD_OFFSET, '0);
      chk(rdat, {31'h0, r.lk[2] & (r.lk[1] | r.lk[0])});
      apb(1'b0, link_flags_pkg::ASSURE_WORD_OFFSET, '0);
      chk(rdat, {16'h0, r.lk[2] ? r.ok & ~r.stp & ~r.er : 16'h0});
      apb(1'b0, link_flags_pkg::RUN_WORD_OFFSET, '0);
      chk(rdat, {16'h0, r.run});
    end
    $display("rows done");
    // Error event unmasked then masked, cleared by writing one
    for (int m = 1; m >= 0; m--) begin
      scan_wait;
      apb(1'b1, link_flags_pkg::INT_MASK_OFFSET, 32'(m));
      apb(1'b1, link_flags_pkg::INT_STATUS_OFFSET, 32'h7);
      link_tx_error <= 1'b1;
      @(posedge clock);
      link_tx_error <= 1'b0;
      scan_wait;
      repeat (2) @(posedge clock);
      chk({31'h0, irq}, 32'(m));
      apb(1'b0, link_flags_pkg::INT_STATUS_OFFSET, '0);
      chk(rdat, 32'h1);
      apb(1'b1, link_flags_pkg::INT_STATUS_OFFSET, 32'h1);
      @(posedge clock);
      chk({31'h0, irq}, 32'h0);
    end
    $display("irq done");
    // Mid-run reset, then a write to a read-only word and a read of an unmapped place
    {link_in_use, link_area_invalid, station_ok, station_stopped,
     station_error, station_run} <= '0;
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    apb(1'b1, link_flags_pkg::ERR_WORD_OFFSET, 32'hffff_ffff);
    foreach (RST[i]) begin
      apb(1'b0, 8'(i * 4), '0);
      chk(rdat, RST[i]);
    end
    apb(1'b0, 8'h20, '0);
    chk({rerr, rdat[30:0]}, 32'h8000_0000);
    $display("reset done");
    tally_and_finish;
  end
endmodule
